// file: inc/emp_pkg.sv
package emp_pkg;
	// ----------------------------------------
	// Widths and timing
	// ----------------------------------------
	localparam int ADDR_W = 24;
	localparam int DATA_W = 32;
	localparam int FLAG_N = 4;
	localparam int BANK_N = 4;
	localparam int CLK_MHZ = 250;
	localparam int STROBE_MIN_NS = 8;
	// Least time, so round up to whole cycles
	localparam int STROBE_CYC = (STROBE_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int PARALLEL_ACQUISITION_INPUT_DIV_DEF = 4;
	// Edges from the start of an access until a pin level taken in it reaches the sequencer
	localparam int ACK_SEEN_CYC = 3;
	// ----------------------------------------
	// Bank decode: top two address bits pick the bank
	// ----------------------------------------
	localparam int BANK_LSB = 22;
	localparam logic [1:0] BOOT_BANK = 2'h1;
	localparam int FLAG_MS_FIRST = 2;
	// ----------------------------------------
	// Data pin function codes
	// ----------------------------------------
	localparam logic [1:0] PIN_EXT_MEMORY_INTERFACE_MODE = 2'h0;
	localparam logic [1:0] PIN_PARALLEL_ACQUISITION_INPUT = 2'h1;
	localparam logic [1:0] PIN_FLAG = 2'h2;
	localparam logic [1:0] PIN_PWM = 2'h3;
	localparam logic [3:0] BANK_IDLE_N = 4'hF;

	typedef enum logic [1:0] {
		EMP_IDLE,
		EMP_ACCESS,
		EMP_DONE
	} emp_state_e;

	typedef logic [DATA_W-1:0][1:0] emp_modes_t;
endpackage : emp_pkg

// file: inc/emp_in_if.sv
`timescale 1ns/100ps
// Raw pin levels and their synchronised copies
interface emp_in_if;
	logic [31:0] data_raw;
	logic ack_raw;
	logic [3:0] flag_raw;
	logic [31:0] data_s;
	logic ack_s;
	logic [3:0] flag_s;
	modport src (output data_raw, output ack_raw, output flag_raw, input data_s, input ack_s, input flag_s);
	modport sync (input data_raw, input ack_raw, input flag_raw, output data_s, output ack_s, output flag_s);
endinterface : emp_in_if

// file: rtl/emp_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser for every pin input of the port
module emp_sync
	import emp_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	emp_in_if.sync pins
);
	localparam int SW = DATA_W + 1 + FLAG_N;

	typedef struct packed {
		logic [SW-1:0] meta;
		logic [SW-1:0] sync;
	} emp_sync_s;

	emp_sync_s s_r;
	emp_sync_s s_nxt;

	// ----------------------------------------
	// First stage feeds only the second
	// ----------------------------------------
	always_comb begin
		s_nxt.meta = {pins.flag_raw, pins.ack_raw, pins.data_raw};
		s_nxt.sync = s_r.meta;
	end

	// Register both stages
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pins.data_s = s_r.sync[DATA_W-1:0];
	assign pins.ack_s = s_r.sync[DATA_W];
	assign pins.flag_s = s_r.sync[SW-1:DATA_W+1];
endmodule : emp_sync

// file: rtl/emp_div.sv
`timescale 1ns/100ps
// Enable pulse every DIV cycles
module emp_div #(
	parameter int DIV = 4
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	output logic tick_o
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

	initial begin
		if (DIV < 1) $error("emp_div: DIV must be at least 1");
	end

	typedef struct packed {
		logic [CW-1:0] cnt;
	} emp_div_s;

	emp_div_s s_r;
	emp_div_s s_nxt;

	// ----------------------------------------
	// Free-running counter
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		if (s_r.cnt == CW'(DIV - 1)) begin
			s_nxt.cnt = '0;
		end else begin
			s_nxt.cnt = s_r.cnt + 1'b1;
		end
	end

	// Register the count
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick_o = (s_r.cnt == CW'(DIV - 1));
endmodule : emp_div

// file: rtl/emp_port.sv
`timescale 1ns/100ps
// Functional notes
// R01: Drive access address on 24-bit bus
// R02: Data pins shared: memory, acquisition, flag, pulse
// R03: Reset leaves data pins memory, flags flags
// R04: Channel 0 samples data pins when enabled
// R05: Acknowledge low stretches the access
// R06: Bank selects 0-1 active low chip selects
// R07: Bank selects decoded, change with address
// R08: Bank selects high when no access runs
// R09: Conditional access asserts select regardless
// R10: Flash boot uses bank select 1
// R11: Read strobe low for every read word
// R12: Write strobe low for every written word
// R13: Flag pins 2-3 carry bank selects 2-3
// R14: Hold strobe, select, address until acknowledge
module emp_port
	import emp_pkg::*;
#(
	parameter int PARALLEL_ACQUISITION_INPUT_DIV = PARALLEL_ACQUISITION_INPUT_DIV_DEF,
	parameter int STROBE_CYCLES = STROBE_CYC
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Core request side
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic req_cond_true_i,
	input wire logic [ADDR_W-1:0] req_addr_i,
	input wire logic [DATA_W-1:0] req_wdata_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [DATA_W-1:0] rsp_rdata_o,
	// Configuration
	input wire logic boot_flash_i,
	input wire logic cfg_load_i,
	input wire logic [2*DATA_W-1:0] cfg_pin_mode_i,
	input wire logic [1:0] cfg_flag_ms_i,
	input wire logic parallel_input_control_i,
	// Other users of shared pins
	input wire logic [DATA_W-1:0] gpio_out_i,
	input wire logic [DATA_W-1:0] gpio_oe_i,
	input wire logic [DATA_W-1:0] pwm_i,
	input wire logic [FLAG_N-1:0] flag_out_i,
	input wire logic [FLAG_N-1:0] flag_oe_i,
	output logic [DATA_W-1:0] gpio_in_o,
	output logic [FLAG_N-1:0] flag_in_o,
	output logic [DATA_W-1:0] input_data_port_o,
	output logic input_data_port_valid_o,
	// External pins
	output logic [ADDR_W-1:0] addr_o,
	input wire logic [DATA_W-1:0] data_i,
	output logic [DATA_W-1:0] data_o,
	output logic [DATA_W-1:0] data_oe_o,
	input wire logic ack_i,
	output logic [1:0] bank_select_n_o,
	output logic rd_n_o,
	output logic wr_n_o,
	input wire logic [FLAG_N-1:0] flag_i,
	output logic [FLAG_N-1:0] flag_o,
	output logic [FLAG_N-1:0] flag_oe_o
);
	// An acknowledge level taken during the access needs ACK_SEEN_CYC edges to
	// reach the sequencer. A shorter strobe would let the acknowledge left high
	// by the idle bus end the access before the far side can pull it low.
	localparam int HOLD_CYC = (STROBE_CYCLES > ACK_SEEN_CYC) ? STROBE_CYCLES : ACK_SEEN_CYC;
	localparam int CW = $clog2(HOLD_CYC + 1);
	// Two selects have pins of their own, the others ride on flag pins
	localparam int BANK_BITS = $clog2(BANK_N);
	localparam int PIN_BANKS = 2;
	localparam int FLAG_BANKS = BANK_N - PIN_BANKS;

	initial begin
		if (STROBE_CYCLES < 1) $error("emp_port: STROBE_CYCLES must be at least 1");
		if (PARALLEL_ACQUISITION_INPUT_DIV < 1) $error("emp_port: PARALLEL_ACQUISITION_INPUT_DIV must be at least 1");
		if (BANK_LSB + BANK_BITS > ADDR_W) $error("emp_port: bank field lies outside the address");
		if (FLAG_MS_FIRST + FLAG_BANKS > FLAG_N) $error("emp_port: select flags lie outside the flag pins");
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		// Access sequencer
		emp_state_e st;
		logic [ADDR_W-1:0] addr;
		logic [BANK_N-1:0] bs_n;
		logic rd_n;
		logic wr_n;
		logic write;
		logic [DATA_W-1:0] wdata;
		logic [CW-1:0] cnt;
		logic [DATA_W-1:0] rdata;
		logic rsp_valid;
		// Pin function configuration
		emp_modes_t modes;
		logic [1:0] flag_ms;
		// Registered pin drivers
		logic [DATA_W-1:0] dout;
		logic [DATA_W-1:0] doe;
		logic [FLAG_N-1:0] fout;
		logic [FLAG_N-1:0] foe;
		// Input channel sample
		logic [DATA_W-1:0] input_data_port;
		logic idp_valid;
	} emp_regs_s;

	emp_regs_s s_r;
	emp_regs_s s_nxt;
	// Divider pulse and synchronised pin levels
	logic parallel_acquisition_input_tick;
	logic [DATA_W-1:0] data_s;
	logic ack_s;
	logic [FLAG_N-1:0] flag_s;

	// Every pin input passes two flops before any logic reads it
	emp_in_if pins ();

	assign pins.data_raw = data_i;
	assign pins.ack_raw = ack_i;
	assign pins.flag_raw = flag_i;
	assign data_s = pins.data_s;
	assign ack_s = pins.ack_s;
	assign flag_s = pins.flag_s;

	emp_sync u_sync (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.pins(pins)
	);

	// Sampling rate of the input channel
	emp_div #(
		.DIV(PARALLEL_ACQUISITION_INPUT_DIV)
	) u_div (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.tick_o(parallel_acquisition_input_tick)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Bank one-hot, active low; boot forces bank 1
	function automatic logic [BANK_N-1:0] bank_dec(input logic [ADDR_W-1:0] a, input logic boot);
		logic [BANK_BITS-1:0] b;
		b = boot ? BANK_BITS'(BOOT_BANK) : a[BANK_LSB +: BANK_BITS]; // R10
		bank_dec = ~(BANK_N'(1) << b); // R07
	endfunction : bank_dec

	// Mask of pins in a given function
	// One compare per pin, small next to the pin multiplexers
	function automatic logic [DATA_W-1:0] mode_mask(input emp_modes_t m, input logic [1:0] code);
		mode_mask = '0;
		for (int i = 0; i < DATA_W; i++) begin
			mode_mask[i] = (m[i] == code);
		end
	endfunction : mode_mask

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [DATA_W-1:0] m_ext_memory_interface_mode;
		logic [DATA_W-1:0] m_parallel_acquisition_input;
		logic [DATA_W-1:0] m_flag;
		logic [DATA_W-1:0] m_pwm;
		logic [BANK_N-1:0] dec;
		m_ext_memory_interface_mode = '0;
		m_parallel_acquisition_input = '0;
		m_flag = '0;
		m_pwm = '0;
		dec = '1;
		s_nxt = s_r;
		// Pulses last one cycle unless set again below
		s_nxt.rsp_valid = 1'b0;
		s_nxt.idp_valid = 1'b0;

		// Pin functions change only on a load
		// A load mid-access switches pins at once; load only while idle
		if (cfg_load_i) begin
			s_nxt.modes = emp_modes_t'(cfg_pin_mode_i); // R02
			s_nxt.flag_ms = cfg_flag_ms_i; // R13
		end

		// Access sequencer
		case (s_r.st)
			EMP_IDLE: begin
				s_nxt.bs_n = BANK_IDLE_N; // R08
				s_nxt.rd_n = 1'b1;
				s_nxt.wr_n = 1'b1;
				// A request is taken only here, so accesses never overlap
				if (req_valid_i) begin
					dec = bank_dec(req_addr_i, boot_flash_i);
					s_nxt.st = EMP_ACCESS;
					s_nxt.addr = req_addr_i; // R01
					// Select follows address even for a false condition
					s_nxt.bs_n = dec; // R06 R09
					// A false condition raises no strobe and drives no data
					s_nxt.rd_n = ~(req_cond_true_i & ~req_write_i); // R11
					s_nxt.wr_n = ~(req_cond_true_i & req_write_i); // R12
					s_nxt.write = req_write_i & req_cond_true_i;
					s_nxt.wdata = req_wdata_i;
					// Count covers the minimum strobe and the synchroniser delay
					s_nxt.cnt = CW'(HOLD_CYC - 1); // R05
				end
			end
			EMP_ACCESS: begin
				// Minimum strobe first, then wait for acknowledge
				if (s_r.cnt != '0) begin
					s_nxt.cnt = s_r.cnt - 1'b1;
				end else if (ack_s) begin // R05 R14
					s_nxt.st = EMP_DONE;
					s_nxt.bs_n = BANK_IDLE_N;
					s_nxt.rd_n = 1'b1;
					s_nxt.wr_n = 1'b1;
					// Read data pass the synchroniser too, so the far side must
					// keep them driven for as long as it holds acknowledge high
					s_nxt.rdata = s_r.rd_n ? s_r.rdata : data_s;
					s_nxt.rsp_valid = 1'b1;
				end
			end
			EMP_DONE: begin
				// One turnaround cycle before the next access
				// Selects stay high for at least this cycle between accesses
				s_nxt.st = EMP_IDLE;
				s_nxt.write = 1'b0;
			end
			// Unused code falls back to idle
			default: begin
				s_nxt.st = EMP_IDLE;
			end
		endcase

		// Data pin drivers, registered so the pins see no glitches
		m_ext_memory_interface_mode = mode_mask(s_r.modes, PIN_EXT_MEMORY_INTERFACE_MODE);
		m_parallel_acquisition_input = mode_mask(s_r.modes, PIN_PARALLEL_ACQUISITION_INPUT);
		m_flag = mode_mask(s_r.modes, PIN_FLAG);
		m_pwm = mode_mask(s_r.modes, PIN_PWM);
		// Memory pins drive only while a true write runs; pulse pins always
		// Flag pin function shares the general purpose drive
		s_nxt.dout = (s_nxt.wdata & m_ext_memory_interface_mode) | (gpio_out_i & m_flag) | (pwm_i & m_pwm); // R02
		s_nxt.doe = ({DATA_W{s_nxt.write}} & m_ext_memory_interface_mode) | (gpio_oe_i & m_flag) | m_pwm;

		// Flag pins, two of them may carry bank selects
		// Banks 2 and 3 show no select while their flag is not switched over
		s_nxt.fout = flag_out_i;
		s_nxt.foe = flag_oe_i; // R03
		for (int k = 0; k < FLAG_BANKS; k++) begin
			if (s_r.flag_ms[k]) begin
				s_nxt.fout[FLAG_MS_FIRST + k] = s_nxt.bs_n[FLAG_MS_FIRST + k]; // R13
				s_nxt.foe[FLAG_MS_FIRST + k] = 1'b1;
			end
		end

		// Parallel input sampling on the divided rate
		// Pins in other functions read as zero in the sample
		if (parallel_input_control_i && parallel_acquisition_input_tick) begin
			s_nxt.input_data_port = data_s & m_parallel_acquisition_input; // R04
			s_nxt.idp_valid = 1'b1;
		end
	end

	// ----------------------------------------
	// Register
	// ----------------------------------------
	// Synchronous reset brings every field to a known level
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			s_r <= '0;
			s_r.st <= EMP_IDLE;
			s_r.bs_n <= BANK_IDLE_N;
			s_r.rd_n <= 1'b1;
			s_r.wr_n <= 1'b1;
			// All-zero modes mean memory mode on every data pin
			s_r.modes <= '0; // R03
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Ready is combinational; a request is taken only in idle
	assign req_ready_o = (s_r.st == EMP_IDLE);
	assign rsp_valid_o = s_r.rsp_valid;
	assign rsp_rdata_o = s_r.rdata;

	// Memory pins
	assign addr_o = s_r.addr; // R01
	assign bank_select_n_o = s_r.bs_n[1:0]; // R06
	assign rd_n_o = s_r.rd_n;
	assign wr_n_o = s_r.wr_n;
	assign data_o = s_r.dout;
	assign data_oe_o = s_r.doe;
	assign flag_o = s_r.fout;
	assign flag_oe_o = s_r.foe;

	// Synchronised pins and the input channel
	assign gpio_in_o = data_s;
	assign flag_in_o = flag_s;
	assign input_data_port_o = s_r.input_data_port;
	assign input_data_port_valid_o = s_r.idp_valid;
endmodule : emp_port

// file: testbench/emp_port_chk.sv
`timescale 1ns/100ps
// Pin rules of the port, seen from its top ports only
module emp_port_chk
	import emp_pkg::*;
(
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic req_cond_true_i,
	input wire logic boot_flash_i,
	input wire logic ack_i,
	input wire logic req_ready_o,
	input wire logic rsp_valid_o,
	input wire logic rd_n_o,
	input wire logic wr_n_o,
	input wire logic [ADDR_W-1:0] req_addr_i,
	input wire logic [ADDR_W-1:0] addr_o,
	input wire logic [1:0] bank_select_n_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	logic tk;
	// A request is taken on this edge
	assign tk = req_valid_i && req_ready_o;
	property p_addr; tk |=> addr_o == $past(req_addr_i); endproperty
	a_addr: assert property (p_addr) else $error("address not on pins");
	property p_sel; tk && !boot_flash_i && !req_addr_i[23] |=> bank_select_n_o == ~(2'h1 << $past(req_addr_i[22])); endproperty
	a_sel: assert property (p_sel) else $error("wrong bank select");
	property p_idle; req_ready_o |-> bank_select_n_o == 2'h3; endproperty
	a_idle: assert property (p_idle) else $error("select active while idle");
	property p_cond; tk && !req_cond_true_i && !req_addr_i[23] |=> rd_n_o && wr_n_o && bank_select_n_o != 2'h3; endproperty
	a_cond: assert property (p_cond) else $error("false condition select");
	property p_boot; tk && boot_flash_i |=> bank_select_n_o == 2'h1; endproperty
	a_boot: assert property (p_boot) else $error("boot not on bank 1");
	property p_rd; tk && req_cond_true_i && !req_write_i |=> !rd_n_o && wr_n_o; endproperty
	a_rd: assert property (p_rd) else $error("read strobe missing");
	property p_wr; tk && req_cond_true_i && req_write_i |=> !wr_n_o && rd_n_o; endproperty
	a_wr: assert property (p_wr) else $error("write strobe missing");
	// Sync delay is three edges, so four low samples must block completion
	property p_wait; (!ack_i) [*4] |-> !rsp_valid_o; endproperty
	a_wait: assert property (p_wait) else $error("completed while ack low");
	property p_hold; !rd_n_o || !wr_n_o |=> rsp_valid_o || ($stable(addr_o) && $stable(bank_select_n_o)); endproperty
	a_hold: assert property (p_hold) else $error("access not held");
	property p_done; rsp_valid_o |=> req_ready_o && !rsp_valid_o; endproperty
	a_done: assert property (p_done) else $error("bad completion");
endmodule : emp_port_chk

bind emp_port emp_port_chk u_emp_port_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
	.req_write_i(req_write_i), .req_cond_true_i(req_cond_true_i), .boot_flash_i(boot_flash_i), .ack_i(ack_i),
	.req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o),
	.req_addr_i(req_addr_i), .addr_o(addr_o), .bank_select_n_o(bank_select_n_o));

// file: testbench/emp_mem_model.sv
`timescale 1ns/100ps
// External memory; ack idles high through its pull-up
module emp_mem_model (
	input wire logic mclk_i,
	input wire logic [23:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [1:0] sel_n_i,
	input wire logic [7:0] waits_i,
	input wire logic src_en_i,
	input wire logic [31:0] src_i,
	output logic [31:0] data_o,
	output logic ack_o
);
	logic [31:0] mem [16];
	logic [31:0] last = 32'h0;
	logic [7:0] cnt = 8'h0;
	logic act;
	assign act = !rd_n_i || !wr_n_i || sel_n_i != 2'h3;
	// Wait states counted from the start of each access
	assign ack_o = !act || cnt >= waits_i;
	// Released bus toggles so stale data can never match
	assign data_o = src_en_i ? src_i : !rd_n_i ? mem[addr_i[3:0]] : ~last;
	always @(posedge mclk_i) begin
		if (!wr_n_i) mem[addr_i[3:0]] <= wdata_i;
		cnt <= act ? cnt + 8'h1 : 8'h0;
		last <= data_o;
	end
endmodule : emp_mem_model

// file: testbench/external_memory_port_pins_test.sv
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t %h %h", $time, a, b); end end
module external_memory_port_pins_test
	import emp_pkg::*;
;
	logic mclk_i = 1'h0, sys_rst_i = 1'h1, req_valid_i = 1'h0, req_write_i = 1'h0, req_cond_true_i = 1'h1;
	logic boot_flash_i = 1'h0, cfg_load_i = 1'h0, parallel_input_control_i = 1'h0, src_en = 1'h0;
	logic req_ready_o, rsp_valid_o, rd_n_o, wr_n_o, ack_i, input_data_port_valid_o;
	logic [31:0] rsp_rdata_o, data_i, data_o, data_oe_o, input_data_port_o, src = 32'h0;
	logic [31:0] gpio_in_o, gpio_out = 32'h2, gpio_oe = 32'h2, pwm = 32'h1;
	logic [3:0] flag_in_o;
	logic [31:0] req_wdata_i = 32'h0;
	logic [23:0] addr_o, req_addr_i = 24'h0;
	logic [63:0] cfg_pin_mode_i = 64'h0;
	logic [1:0] bank_select_n_o, cfg_flag_ms_i = 2'h0;
	logic [3:0] flag_o, flag_oe_o, flag_out_i = 4'hA, flag_oe_i = 4'h5, flag_i = 4'h0;
	logic [7:0] waits = 8'h0;
	logic [10:0] snap;
	int num_errors = 0, tests_run = 0, cyc;
	emp_port u_emp_port (.mclk_i, .sys_rst_i, .req_valid_i, .req_write_i, .req_cond_true_i, .req_addr_i,
		.req_wdata_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .boot_flash_i, .cfg_load_i, .cfg_pin_mode_i,
		.cfg_flag_ms_i, .parallel_input_control_i, .gpio_out_i(gpio_out), .gpio_oe_i(gpio_oe), .pwm_i(pwm),
		.flag_out_i, .flag_oe_i, .gpio_in_o, .flag_in_o, .input_data_port_o, .input_data_port_valid_o,
		.addr_o, .data_i, .data_o, .data_oe_o, .ack_i, .bank_select_n_o, .rd_n_o, .wr_n_o, .flag_i, .flag_o, .flag_oe_o);
	emp_mem_model u_emp_mem_model (.mclk_i, .addr_i(addr_o), .wdata_i(data_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
		.sel_n_i(bank_select_n_o), .waits_i(waits), .src_en_i(src_en), .src_i(src), .data_o(data_i), .ack_o(ack_i));
	initial begin
		forever #2 mclk_i = ~mclk_i;
	end
	// One access; pins are snapshotted in its first cycle
	task automatic acc(input logic w, input logic c, input logic [23:0] a, input logic [31:0] d);
		cyc = 0;
		while (!req_ready_o) @(negedge mclk_i);
		{req_valid_i, req_write_i, req_cond_true_i, req_addr_i, req_wdata_i} = {1'h1, w, c, a, d};
		@(negedge mclk_i);
		req_valid_i = 1'h0;
		snap = {data_oe_o[0], flag_oe_o, flag_o, bank_select_n_o};
		while (!rsp_valid_o && cyc < 500) begin
			@(negedge mclk_i);
			cyc++;
		end
		`CHK(rsp_valid_o, 1'h1)
		@(negedge mclk_i);
	endtask : acc
	task automatic t_reset;
		`CHK(bank_select_n_o, 2'h3)
		`CHK(data_oe_o, 32'h0)
		`CHK(flag_oe_o, 4'h5)
		$display("reset done");
	endtask : t_reset
	task automatic t_rw;
		acc(1'h1, 1'h1, 24'h000003, 32'hA5A51234);
		`CHK(snap[1:0], 2'h2)
		`CHK(snap[10], 1'h1)
		acc(1'h1, 1'h1, 24'h400005, 32'h0F0FC3C3);
		`CHK(snap[1:0], 2'h1)
		acc(1'h0, 1'h1, 24'h400005, 32'h0);
		`CHK(rsp_rdata_o, 32'h0F0FC3C3)
		waits = 8'h14;
		acc(1'h0, 1'h1, 24'h000003, 32'h0);
		`CHK(rsp_rdata_o, 32'hA5A51234)
		`CHK(cyc >= 20, 1'h1)
		waits = 8'h0;
		acc(1'h0, 1'h0, 24'h000005, 32'h0);
		`CHK(rsp_rdata_o, 32'hA5A51234)
		`CHK(snap[1:0], 2'h2)
		$display("rw done");
	endtask : t_rw
	task automatic t_boot;
		boot_flash_i = 1'h1;
		acc(1'h0, 1'h1, 24'h000005, 32'h0);
		`CHK(snap[1:0], 2'h1)
		boot_flash_i = 1'h0;
		flag_out_i = 4'h5;
		{cfg_flag_ms_i, cfg_load_i} = 3'h7;
		@(negedge mclk_i);
		cfg_load_i = 1'h0;
		acc(1'h0, 1'h1, 24'h800003, 32'h0);
		`CHK(snap[9:2], 8'hD9)
		$display("boot done");
	endtask : t_boot
	task automatic t_parallel_acquisition_input;
		{src, src_en, parallel_input_control_i, cfg_load_i} = {32'h5AC30F96, 3'h7};
		cfg_pin_mode_i = {{30{2'h1}}, 2'h2, 2'h3};
		flag_i = 4'h9;
		@(negedge mclk_i);
		cfg_load_i = 1'h0;
		repeat (8) @(negedge mclk_i);
		cyc = 0;
		while (!input_data_port_valid_o && cyc < 20) begin
			@(negedge mclk_i);
			cyc++;
		end
		`CHK(input_data_port_valid_o, 1'h1)
		`CHK(input_data_port_o, 32'h5AC30F94)
		`CHK(data_oe_o, 32'h3)
		`CHK(data_o, 32'h3)
		`CHK(gpio_in_o, 32'h5AC30F96)
		`CHK(flag_in_o, 4'h9)
		$display("parallel_acquisition_input done");
	endtask : t_parallel_acquisition_input
	task end_sim;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim
	initial begin
		repeat (16) @(negedge mclk_i);
		sys_rst_i = 1'h0;
		@(negedge mclk_i);
		t_reset();
		t_rw();
		t_boot();
		t_parallel_acquisition_input();
		end_sim();
	end
	// Whole run is about a hundred cycles
	initial begin
		repeat (20000) @(posedge mclk_i);
		num_errors++;
		end_sim();
	end
endmodule : external_memory_port_pins_test
